// [verilog/scg_top.sv]
// Clock generator control: registers, stop sequencing, slow clock
`timescale 1ns/10ps
`include "scg_defs.svh"
module scg_top #(
  parameter int WAIT_CNT0 = `SCG_NS2CYC(`SCG_WAIT0_NS),
  parameter int WAIT_CNT1 = `SCG_NS2CYC(`SCG_WAIT1_NS),
  parameter int WAIT_CNT2 = `SCG_NS2CYC(`SCG_WAIT2_NS),
  parameter int WAIT_CNT3 = `SCG_NS2CYC(`SCG_WAIT3_NS)
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Configuration byte
  input  wire scg_pkg::scg_src_t opt_clk_src,
  input  wire logic              opt_slow_stop_ok,
  // Memory-manipulation access
  input  wire logic [15:0]       reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_bit_wr,
  input  wire logic [2:0]        reg_bit_sel,
  input  wire logic              reg_bit_val,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // Stop mode
  input  wire logic              stop_req,
  input  wire logic              stop_release,
  // Derived clocks
  output logic                   cpu_clk_en,
  output logic                   periph_clk_en,
  output logic                   instr_slot,
  output logic                   interval_clk_en,
  // Oscillator controls
  output logic                   hs_osc_run,
  output logic                   xtal_osc_run,
  output logic                   ext_clk_gate,
  output logic                   slow_osc_run,
  output logic                   stab_wait_busy,
  // Pin release
  output logic                   resonator_pin_a_is_port,
  output logic                   resonator_pin_b_is_port,
  output logic                   external_clock_pin_is_port
);
  import scg_pkg::*;

  localparam logic [20:0] W0 = 21'(WAIT_CNT0 - 1);
  localparam logic [20:0] W1 = 21'(WAIT_CNT1 - 1);
  localparam logic [20:0] W2 = 21'(WAIT_CNT2 - 1);
  localparam logic [20:0] W3 = 21'(WAIT_CNT3 - 1);
  localparam logic [9:0]  SLOW_LAST = 10'(`SCG_SLOW_CNT - 1);

  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] mask,
                                     input logic byte_we, input logic bit_we,
                                     input logic [7:0] wd, input logic [2:0] bsel,
                                     input logic bval);
    logic [7:0] v;
    v = cur;
    if (byte_we) begin
      v = wd;
    end else if (bit_we) begin
      v[bsel] = bval;
    end
    upd = v & mask;
  endfunction

  scg_div_if dif ();

  logic [7:0]  peripheral_prescale_control_ff;
  logic [7:0]  cpu_clock_divide_control_ff;
  logic [7:0]  slow_osc_mode_reg_ff;
  logic [7:0]  stabilization_wait_select_ff;
  logic [7:0]  reg_rdata_ff;
  scg_src_t    src_ff;
  logic        slow_ok_ff;
  logic        opt_taken_ff;
  scg_state_t  state_ff;
  scg_state_t  nxt_state;
  logic [20:0] wait_cnt_ff;
  logic [20:0] nxt_wait_cnt;
  logic [9:0]  slow_cnt_ff;
  logic        slot_par_ff;
  logic        instr_slot_ff;
  logic        interval_ff;
  logic        hs_run_ff;
  logic        xtal_run_ff;
  logic        ext_gate_ff;
  logic        slow_run_ff;
  logic        wait_busy_ff;
  logic        pin_a_ff;
  logic        pin_b_ff;
  logic        pin_ext_ff;

  ////////////////////////////////////////////////////////////////////
  // Register decode
  wire hit_presc  = (reg_addr == `SCG_ADDR_PRESC);
  wire hit_cpudiv = (reg_addr == `SCG_ADDR_CPUDIV);
  wire hit_slowm  = (reg_addr == `SCG_ADDR_SLOWM);
  wire hit_stab   = (reg_addr == `SCG_ADDR_STAB);
  wire [7:0] nxt_presc  = upd(peripheral_prescale_control_ff, `SCG_MASK_PRESC,
                              reg_wr && hit_presc, reg_bit_wr && hit_presc,
                              reg_wdata, reg_bit_sel, reg_bit_val);
  wire [7:0] nxt_cpudiv = upd(cpu_clock_divide_control_ff, `SCG_MASK_CPUDIV,
                              reg_wr && hit_cpudiv, reg_bit_wr && hit_cpudiv,
                              reg_wdata, reg_bit_sel, reg_bit_val);
  wire [7:0] nxt_slowm  = upd(slow_osc_mode_reg_ff, `SCG_MASK_SLOWM,
                              reg_wr && hit_slowm, reg_bit_wr && hit_slowm,
                              reg_wdata, reg_bit_sel, reg_bit_val);
  // Wait select takes byte writes only
  wire [7:0] nxt_stab   = upd(stabilization_wait_select_ff, `SCG_MASK_STAB,
                              reg_wr && hit_stab, 1'b0,
                              reg_wdata, reg_bit_sel, reg_bit_val);
  wire [7:0] nxt_rdata  = !reg_rd    ? 8'h00 :
                          hit_presc  ? peripheral_prescale_control_ff :
                          hit_cpudiv ? cpu_clock_divide_control_ff :
                          hit_slowm  ? slow_osc_mode_reg_ff :
                          hit_stab   ? stabilization_wait_select_ff : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_prescale_control_ff <= `SCG_RST_PRESC;
      cpu_clock_divide_control_ff    <= `SCG_RST_CPUDIV;
      slow_osc_mode_reg_ff           <= `SCG_RST_SLOWM;
      stabilization_wait_select_ff   <= `SCG_RST_STAB;
      reg_rdata_ff                   <= 8'h00;
    end else begin
      peripheral_prescale_control_ff <= nxt_presc;
      cpu_clock_divide_control_ff    <= nxt_cpudiv;
      slow_osc_mode_reg_ff           <= nxt_slowm;
      stabilization_wait_select_ff   <= nxt_stab;
      reg_rdata_ff                   <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Configuration byte capture
  // source from configuration byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_ff       <= `SCG_SRC_HS;
      slow_ok_ff   <= 1'b0;
      opt_taken_ff <= 1'b0;
    end else if (!opt_taken_ff) begin
      src_ff       <= opt_clk_src;
      slow_ok_ff   <= opt_slow_stop_ok;
      opt_taken_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stop sequencing
  wire       is_xtal = (src_ff == `SCG_SRC_XTAL);
  wire [1:0] wsel    = stabilization_wait_select_ff[1:0];
  wire [20:0] wait_load = (wsel == 2'h0) ? W0 : (wsel == 2'h1) ? W1 :
                          (wsel == 2'h2) ? W2 : W3;

  always_comb begin
    nxt_state    = state_ff;
    nxt_wait_cnt = wait_cnt_ff;
    case (state_ff)
      ST_RUN: begin
        if (stop_req && opt_taken_ff) begin
          nxt_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (stop_release && is_xtal) begin
          nxt_state    = ST_WAIT;
          nxt_wait_cnt = wait_load;
        end else if (stop_release) begin
          nxt_state = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (wait_cnt_ff == 21'h0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_wait_cnt = wait_cnt_ff - 21'h1;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ST_RUN;
      wait_cnt_ff <= 21'h0;
    end else begin
      state_ff    <= nxt_state;
      wait_cnt_ff <= nxt_wait_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Divider hookup
  // select from both registers
  assign dif.sel_p = peripheral_prescale_control_ff[1:0];
  assign dif.sel_c = cpu_clock_divide_control_ff[`SCG_BIT_CPU_DIV];
  assign dif.run   = (state_ff == ST_RUN) && opt_taken_ff;

  scg_divider u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .dif     (dif)
  );

  ////////////////////////////////////////////////////////////////////
  // Slow oscillator and instruction slot
  // stop bit honoured when allowed
  wire slow_stop = slow_ok_ff && slow_osc_mode_reg_ff[`SCG_BIT_SLOW_STOP];
  wire slow_wrap = (slow_cnt_ff == SLOW_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_cnt_ff   <= 10'h000;
      interval_ff   <= 1'b0;
      slot_par_ff   <= 1'b0;
      instr_slot_ff <= 1'b0;
    end else begin
      slow_cnt_ff   <= (slow_stop || slow_wrap) ? 10'h000 : slow_cnt_ff + 10'h001;
      interval_ff   <= !slow_stop && slow_wrap;
      slot_par_ff   <= dif.run ? (slot_par_ff ^ dif.cpu_tick) : 1'b0;
      instr_slot_ff <= dif.run && dif.cpu_tick && slot_par_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Oscillator and pin controls
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_run_ff    <= 1'b1;
      xtal_run_ff  <= 1'b0;
      ext_gate_ff  <= 1'b0;
      slow_run_ff  <= 1'b1;
      wait_busy_ff <= 1'b0;
      pin_a_ff     <= 1'b0;
      pin_b_ff     <= 1'b0;
      pin_ext_ff   <= 1'b0;
    end else begin
      hs_run_ff    <= (src_ff == `SCG_SRC_HS) && (nxt_state == ST_RUN);
      xtal_run_ff  <= is_xtal && (nxt_state != ST_STOP);
      ext_gate_ff  <= (src_ff == `SCG_SRC_EXT) && (nxt_state == ST_RUN);
      slow_run_ff  <= !slow_stop;
      wait_busy_ff <= (nxt_state == ST_WAIT);
      pin_a_ff     <= opt_taken_ff && (src_ff == `SCG_SRC_HS);
      pin_b_ff     <= opt_taken_ff && !is_xtal;
      pin_ext_ff   <= opt_taken_ff && (src_ff == `SCG_SRC_HS);
    end
  end

  assign reg_rdata                  = reg_rdata_ff;
  assign cpu_clk_en                 = dif.cpu_tick;
  assign periph_clk_en              = dif.periph_tick;
  assign instr_slot                 = instr_slot_ff;
  assign interval_clk_en            = interval_ff;
  assign hs_osc_run                 = hs_run_ff;
  assign xtal_osc_run               = xtal_run_ff;
  assign ext_clk_gate               = ext_gate_ff;
  assign slow_osc_run               = slow_run_ff;
  assign stab_wait_busy             = wait_busy_ff;
  assign resonator_pin_a_is_port    = pin_a_ff;
  assign resonator_pin_b_is_port    = pin_b_ff;
  assign external_clock_pin_is_port = pin_ext_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_reset_val;
    @(posedge sys_clk) disable iff (!rst_n)
    !opt_taken_ff |-> peripheral_prescale_control_ff == `SCG_RST_PRESC
                   && cpu_clock_divide_control_ff == `SCG_RST_CPUDIV;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("Divider reset value wrong");

  property p_bit_write;
    @(posedge sys_clk) disable iff (!rst_n)
    (reg_bit_wr && !reg_wr && hit_presc && reg_bit_sel == 3'h0)
      |=> peripheral_prescale_control_ff[0] == $past(reg_bit_val)
       && peripheral_prescale_control_ff[1] == $past(peripheral_prescale_control_ff[1]);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("Bit write wrong");

  property p_stop_halt;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_ff == ST_RUN && stop_req && opt_taken_ff)
      |=> !hs_osc_run && !xtal_osc_run && !ext_clk_gate ##1 !cpu_clk_en;
  endproperty
  a_stop_halt: assert property (p_stop_halt) else $error("Clock runs in stop");

  property p_xtal_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_ff == ST_STOP && stop_release && is_xtal && wsel == 2'h0)
      |=> (stab_wait_busy && xtal_osc_run && !dif.run) [*8];
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("Crystal wait too short");

  property p_no_wait;
    @(posedge sys_clk) disable iff (!rst_n)
    (state_ff == ST_STOP && stop_release && !is_xtal) |=> state_ff == ST_RUN ##0 !stab_wait_busy;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("Wait without crystal");

  property p_slow_locked;
    @(posedge sys_clk) disable iff (!rst_n)
    (opt_taken_ff && !slow_ok_ff) |=> slow_osc_run;
  endproperty
  a_slow_locked: assert property (p_slow_locked) else $error("Slow osc stopped");

  property p_slow_stop;
    @(posedge sys_clk) disable iff (!rst_n)
    (slow_ok_ff && slow_osc_mode_reg_ff[0]) |=> !slow_osc_run ##0 !interval_clk_en;
  endproperty
  a_slow_stop: assert property (p_slow_stop) else $error("Stop bit ignored");

  property p_pins;
    @(posedge sys_clk) disable iff (!rst_n)
    opt_taken_ff |=> resonator_pin_b_is_port == (src_ff != `SCG_SRC_XTAL)
                  && resonator_pin_a_is_port == (src_ff == `SCG_SRC_HS);
  endproperty
  a_pins: assert property (p_pins) else $error("Pin release wrong");

  property p_slot;
    @(posedge sys_clk) disable iff (!rst_n)
    instr_slot |-> $past(cpu_clk_en);
  endproperty
  a_slot: assert property (p_slot) else $error("Instruction slot off tick");

  c_stop_xtal: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_ff == ST_WAIT && wait_cnt_ff == 21'h0);
  c_slow_stop: cover property (@(posedge sys_clk) disable iff (!rst_n) !slow_osc_run);
  c_slot: cover property (@(posedge sys_clk) disable iff (!rst_n) instr_slot);
endmodule

// [verilog/scg_defs.svh]
// Constants for the system clock generator and divider
// Behaviour
// - Reset loads both divider registers with 02H
// - Divider registers accept bit and byte writes
// - CPU clock from prescale and divide bits
// - Peripheral clock /2 at 01H, /4 at 02H
// - Shortest instruction takes two CPU clocks
// - Internal fast oscillator halts in stop mode
// - Crystal oscillator stops in stop mode
// - External clock gated off in stop mode
// - Clock source chosen by configuration byte
// - Fast internal source frees resonator pins
// - External source frees second resonator pin
// - Interval clock feeds watchdog and 8-bit timer
// - Slow oscillator stoppable only when configuration allows
// - Stop bit: 1 stops, resets 0, maybe ignored
// - Crystal wait after stop release only
// - Peripheral clock first, CPU clock from it
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// Register addresses
`define SCG_ADDR_PRESC     16'hfff3
`define SCG_ADDR_CPUDIV    16'hfffb
`define SCG_ADDR_SLOWM     16'hff58
`define SCG_ADDR_STAB      16'hfff4

// Reset values and writable masks
`define SCG_RST_PRESC      8'h02
`define SCG_RST_CPUDIV     8'h02
`define SCG_RST_SLOWM      8'h00
`define SCG_RST_STAB       8'h00
`define SCG_MASK_PRESC     8'h03
`define SCG_MASK_CPUDIV    8'h02
`define SCG_MASK_SLOWM     8'h01
`define SCG_MASK_STAB      8'h03

// Field positions
`define SCG_BIT_CPU_DIV    1
`define SCG_BIT_SLOW_STOP  0

// Configuration byte source codes
`define SCG_SRC_HS         2'h0
`define SCG_SRC_XTAL       2'h1
`define SCG_SRC_EXT        2'h2

// Timing
`define SCG_CLK_PERIOD_NS  8
`define SCG_SYS_KHZ        125000
`define SCG_SLOW_KHZ       240
`define SCG_SLOW_CNT       (`SCG_SYS_KHZ / `SCG_SLOW_KHZ)
`define SCG_WAIT0_NS       102400
`define SCG_WAIT1_NS       409600
`define SCG_WAIT2_NS       3270000
`define SCG_WAIT3_NS       13100000
`define SCG_NS2CYC(t)      (((t) + `SCG_CLK_PERIOD_NS - 1) / `SCG_CLK_PERIOD_NS)

`endif

// [verilog/scg_pkg.sv]
// Types for the system clock generator
package scg_pkg;
  typedef logic [1:0] scg_src_t;
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WAIT} scg_state_t;
endpackage

// [verilog/scg_div_if.sv]
// Carrier between clock controller and divider
`timescale 1ns/10ps
interface scg_div_if;
  logic [1:0] sel_p;
  logic       sel_c;
  logic       run;
  logic       periph_tick;
  logic       cpu_tick;
  modport ctrl (output sel_p, output sel_c, output run, input periph_tick, input cpu_tick);
  modport div  (input sel_p, input sel_c, input run, output periph_tick, output cpu_tick);
endinterface

// [verilog/scg_divider.sv]
// Prescaler: peripheral tick, then CPU tick from it
`timescale 1ns/10ps
`include "scg_defs.svh"
module scg_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Controller side
  scg_div_if.div   dif
);
  import scg_pkg::*;

  function automatic logic [1:0] p_last(input logic [1:0] sel);
    p_last = (sel == 2'h2) ? 2'h3 : sel;
  endfunction

  logic [1:0] act_p_ff;
  logic       act_c_ff;
  logic [1:0] p_cnt_ff;
  logic [1:0] c_cnt_ff;
  logic       periph_tick_ff;
  logic       cpu_tick_ff;
  logic [4:0] gap_ff;
  logic [4:0] exp_ff;

  wire [1:0] p_lim = p_last(act_p_ff);
  wire [1:0] c_lim = act_c_ff ? 2'h3 : 2'h0;
  wire       p_hit = dif.run && (p_cnt_ff == p_lim);
  wire       c_hit = p_hit && (c_cnt_ff == c_lim);
  wire       reload = c_hit || !dif.run;
  wire [1:0] nxt_p_cnt = reload ? 2'h0 : (p_hit ? 2'h0 : p_cnt_ff + 2'h1);
  wire [1:0] nxt_c_cnt = reload ? 2'h0 : (p_hit ? c_cnt_ff + 2'h1 : c_cnt_ff);
  wire [4:0] nxt_exp = ({3'h0, p_last(dif.sel_p)} + 5'h01) * (dif.sel_c ? 5'h04 : 5'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_p_ff <= 2'h2;
      act_c_ff <= 1'b0;
      p_cnt_ff <= 2'h0;
      c_cnt_ff <= 2'h0;
    end else begin
      p_cnt_ff <= nxt_p_cnt;
      c_cnt_ff <= nxt_c_cnt;
      if (reload) begin
        act_p_ff <= dif.sel_p;
        act_c_ff <= dif.sel_c;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_tick_ff <= 1'b0;
      cpu_tick_ff    <= 1'b0;
    end else begin
      periph_tick_ff <= p_hit;
      cpu_tick_ff    <= c_hit;
    end
  end

  assign dif.periph_tick = periph_tick_ff;
  assign dif.cpu_tick    = cpu_tick_ff;

  ////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff <= 5'h00;
      exp_ff <= 5'h04;
    end else begin
      gap_ff <= reload ? 5'h00 : gap_ff + 5'h01;
      if (reload) begin
        exp_ff <= nxt_exp;
      end
    end
  end

  property p_cpu_period;
    @(posedge sys_clk) disable iff (!rst_n)
    c_hit |-> (gap_ff + 5'h01 == exp_ff);
  endproperty
  a_cpu_period: assert property (p_cpu_period) else $error("CPU tick period wrong");

  property p_periph_div4;
    @(posedge sys_clk) disable iff (!rst_n || !dif.run)
    (p_hit && !c_hit && act_p_ff == 2'h2) |=> !p_hit [*3] ##1 p_hit;
  endproperty
  a_periph_div4: assert property (p_periph_div4) else $error("Peripheral not fx/4");

  property p_periph_div2;
    @(posedge sys_clk) disable iff (!rst_n || !dif.run)
    (p_hit && !c_hit && act_p_ff == 2'h1) |=> !p_hit ##1 p_hit;
  endproperty
  a_periph_div2: assert property (p_periph_div2) else $error("Peripheral not fx/2");

  property p_cpu_on_periph;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_tick_ff |-> periph_tick_ff;
  endproperty
  a_cpu_on_periph: assert property (p_cpu_on_periph) else $error("CPU tick off grid");

  property p_sel_stable;
    @(posedge sys_clk) disable iff (!rst_n)
    (dif.run && !c_hit && $past(dif.run)) |=> $stable(act_p_ff) && $stable(act_c_ff);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("Divider changed mid period");

  c_div16: cover property (@(posedge sys_clk) disable iff (!rst_n)
    c_hit && exp_ff == 5'h10);
  c_div1: cover property (@(posedge sys_clk) disable iff (!rst_n)
    c_hit && exp_ff == 5'h01);
endmodule

// [sim/scg_osc_model.sv]
// Resonator model on the far side of the crystal pins
`timescale 1ns/10ps
module scg_osc_model #(
  parameter int START_CYC = 8
) (
  // Clock
  input  wire logic sys_clk,
  // Device side
  input  wire logic xtal_osc_run,
  input  wire logic pin_a_is_port,
  input  wire logic pin_b_is_port,
  // Status
  output logic      osc_ok
);
  int cnt = 0;

  always @(posedge sys_clk) begin
    if (!xtal_osc_run || pin_a_is_port || pin_b_is_port) begin
      cnt <= 0;
    end else if (cnt < START_CYC) begin
      cnt <= cnt + 1;
    end
  end
  assign osc_ok = (cnt >= START_CYC);
endmodule

// [sim/system_clock_generator_divider_test.sv]
// Self-checking bench for the clock generator and divider
`timescale 1ns/10ps
`include "scg_defs.svh"
module system_clock_generator_divider_test;
  import scg_pkg::*;
  typedef struct {logic [7:0] pp; logic [7:0] pc; int cyc; int np;} scg_row_t;
  logic        sys_clk, rst_n, opt_slow_stop_ok, reg_wr, reg_bit_wr, reg_bit_val, reg_rd;
  logic        stop_req, stop_release, cpu_clk_en, periph_clk_en, instr_slot, interval_clk_en;
  logic        hs_osc_run, xtal_osc_run, ext_clk_gate, slow_osc_run, stab_wait_busy;
  logic        pin_a, pin_b, pin_x, osc_ok;
  scg_src_t    opt_clk_src;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [2:0]  reg_bit_sel;
  int          n_fail, samples_checked;
  scg_row_t    rows [6] = '{'{8'h00, 8'h00, 1, 1}, '{8'h01, 8'h00, 2, 1}, '{8'h00, 8'h02, 4, 4},
                            '{8'h02, 8'h00, 4, 1}, '{8'h01, 8'h02, 8, 4}, '{8'h02, 8'h02, 16, 4}};

  scg_top #(.WAIT_CNT0(10), .WAIT_CNT1(12), .WAIT_CNT2(14), .WAIT_CNT3(16)) scg_top_i (
    .sys_clk, .rst_n, .opt_clk_src, .opt_slow_stop_ok, .reg_addr, .reg_wr, .reg_wdata,
    .reg_bit_wr, .reg_bit_sel, .reg_bit_val, .reg_rd, .reg_rdata, .stop_req, .stop_release,
    .cpu_clk_en, .periph_clk_en, .instr_slot, .interval_clk_en, .hs_osc_run, .xtal_osc_run,
    .ext_clk_gate, .slow_osc_run, .stab_wait_busy, .resonator_pin_a_is_port(pin_a),
    .resonator_pin_b_is_port(pin_b), .external_clock_pin_is_port(pin_x));
  scg_osc_model scg_osc_model_i (.sys_clk, .xtal_osc_run, .pin_a_is_port(pin_a),
    .pin_b_is_port(pin_b), .osc_ok);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rst(input scg_src_t s, input logic ok);
    @(posedge sys_clk);
    rst_n            <= 1'b0;
    opt_clk_src      <= s;
    opt_slow_stop_ok <= ok;
    repeat (2) @(posedge sys_clk);
    rst_n            <= 1'b1;
    repeat (3) tick();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic bw(input logic [15:0] a, input logic [2:0] s, input logic v);
    @(posedge sys_clk);
    reg_addr    <= a;
    reg_bit_sel <= s;
    reg_bit_val <= v;
    reg_bit_wr  <= 1'b1;
    @(posedge sys_clk);
    reg_bit_wr  <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic stp(input logic rel);
    @(posedge sys_clk);
    stop_req     <= !rel;
    stop_release <= rel;
    @(posedge sys_clk);
    stop_req     <= 1'b0;
    stop_release <= 1'b0;
    #1;
  endtask
  task automatic sync;
    for (int i = 0; i < 40 && cpu_clk_en !== 1'b1; i++) tick();
    if (cpu_clk_en !== 1'b1) n_fail++;
  endtask
  task automatic meas(input scg_row_t r);
    int n, p, s, k;
    sync();
    tick();
    sync();
    n = 0;
    p = 0;
    s = 0;
    k = 0;
    while (k < 2 && n < 80) begin
      tick();
      n++;
      p += int'(periph_clk_en);
      s += int'(instr_slot);
      k += int'(cpu_clk_en);
    end
    chk("cpu period", 16'(n), 16'(2 * r.cyc));
    chk("periph pulses", 16'(p), 16'(2 * r.np));
    chk("instr slots", 16'(s), 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    close_out();
  end

  initial begin
    int n, p;
    {rst_n, opt_slow_stop_ok, reg_wr, reg_bit_wr, reg_bit_val, reg_rd} = '0;
    {stop_req, stop_release, reg_addr, reg_wdata, reg_bit_sel} = '0;
    opt_clk_src = `SCG_SRC_HS;
    n_fail = 0;
    samples_checked = 0;
    rst(`SCG_SRC_HS, 1'b0);
    rd("presc reset", `SCG_ADDR_PRESC, 8'h02);
    rd("cpudiv reset", `SCG_ADDR_CPUDIV, 8'h02);
    rd("slow mode reset", `SCG_ADDR_SLOWM, 8'h00);
    chk("pins freed", {13'h0000, pin_a, pin_b, pin_x}, 16'h0007);
    foreach (rows[i]) begin
      wr(`SCG_ADDR_PRESC, rows[i].pp);
      bw(`SCG_ADDR_CPUDIV, 3'd1, rows[i].pc[1]);
      rd("presc", `SCG_ADDR_PRESC, rows[i].pp);
      rd("cpudiv", `SCG_ADDR_CPUDIV, rows[i].pc);
      meas(rows[i]);
    end
    wr(`SCG_ADDR_CPUDIV, 8'hff);
    rd("cpudiv reserved", `SCG_ADDR_CPUDIV, 8'h02);
    rd("unmapped", 16'h0000, 8'h00);
    bw(`SCG_ADDR_PRESC, 3'd1, 1'b0);
    bw(`SCG_ADDR_PRESC, 3'd0, 1'b1);
    rd("presc bit write", `SCG_ADDR_PRESC, 8'h01);
    stp(1'b0);
    p = 0;
    repeat (20) begin
      tick();
      p += int'(cpu_clk_en);
    end
    chk("fast osc in stop", {hs_osc_run, 15'(p)}, 16'h0000);
    stp(1'b1);
    chk("fast osc release", {14'h0000, hs_osc_run, stab_wait_busy}, 16'h0002);
    wr(`SCG_ADDR_SLOWM, 8'h01);
    tick();
    chk("slow locked on", {15'h0000, slow_osc_run}, 16'h0001);
    rd("slow bit stored", `SCG_ADDR_SLOWM, 8'h01);
    for (n = 0; n < 1200 && interval_clk_en !== 1'b1; n++) tick();
    n = 0;
    do begin
      tick();
      n++;
    end while (interval_clk_en !== 1'b1 && n < 1200);
    chk("interval period", 16'(n), 16'd520);
    rst(`SCG_SRC_XTAL, 1'b1);
    chk("xtal pins", {13'h0000, pin_a, pin_b, pin_x}, 16'h0000);
    wr(`SCG_ADDR_SLOWM, 8'h01);
    tick();
    chk("slow stopped", {15'h0000, slow_osc_run}, 16'h0000);
    bw(`SCG_ADDR_SLOWM, 3'd0, 1'b0);
    tick();
    chk("slow restarted", {15'h0000, slow_osc_run}, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(`SCG_ADDR_STAB, 8'(k));
      stp(1'b0);
      chk("xtal in stop", {15'h0000, xtal_osc_run}, 16'h0000);
      stp(1'b1);
      for (n = 0; n < 60 && stab_wait_busy === 1'b1; n++) tick();
      chk("xtal wait", 16'(n), 16'(10 + 2 * k));
      chk("resonator stable", {15'h0000, osc_ok}, 16'h0001);
    end
    bw(`SCG_ADDR_STAB, 3'd1, 1'b0);
    rd("wait select bit write", `SCG_ADDR_STAB, 8'h03);
    rst(`SCG_SRC_EXT, 1'b0);
    chk("ext pins", {13'h0000, pin_a, pin_b, pin_x}, 16'h0002);
    stp(1'b0);
    chk("ext gated", {15'h0000, ext_clk_gate}, 16'h0000);
    stp(1'b1);
    chk("ext release", {14'h0000, ext_clk_gate, stab_wait_busy}, 16'h0002);
    close_out();
  end
endmodule
